// ===== shared/ibu_pkg.sv
// Package of constants and carrier types for the instruction breakpoint unit
package ibu_pkg;

  // Coprocessor decode
  localparam logic [3:0]  CP_NUM_SYS     = 4'hf;
  localparam logic [3:0]  CRN_BREAK      = 4'he;

  // Register layout
  localparam int          BREAK_WIDTH    = 32;
  localparam int          EN_BIT         = 0;
  localparam int          RSVD_BIT       = 1;
  localparam int          ADDR_LSB       = 2;
  localparam int          ADDR_MSB       = 31;
  localparam int          ADDR_WIDTH     = ADDR_MSB - ADDR_LSB + 1;
  localparam logic        EN_RESET       = 1'h0;
  localparam logic [29:0] ADDR_RESET     = 30'h0;
  localparam logic [31:0] READ_IDLE      = 32'h0;

  // Fetch-to-execute stages tracked between fetch and execution
  localparam int          PIPE_DEPTH     = 2;

  // Coprocessor access handshake states
  typedef enum logic [0:0] {
    IBU_CP_IDLE = 1'b0,
    IBU_CP_RESP = 1'b1
  } ibu_cp_state_e;

  // Coprocessor register transfer request from the core
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [3:0]  cpNum;
    logic [3:0]  crn;
    logic        privileged;
    logic [31:0] wdata;
  } ibu_cp_req_s;

  // Fetch stage report
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } ibu_fetch_s;

  // Execute stage report
  typedef struct packed {
    logic        valid;
    logic [31:0] pc;
  } ibu_exec_s;

  // One tracked instruction in the fetch-to-execute pipe
  typedef struct packed {
    logic        valid;
    logic        hit;
    logic [29:0] addr;
  } ibu_entry_s;

endpackage

// ===== src/ibu_breakpoint.sv
// Instruction address breakpoint unit with its coprocessor register access
`timescale 1ns/1ps

module ibu_breakpoint (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  // Coprocessor register transfer side
  input  ibu_pkg::ibu_cp_req_s   cpReq,
  output logic                   cpBusy_r,
  output logic                   cpAccept_r,
  output logic                   cpUndef_r,
  output logic                   cpRdValid_r,
  output logic [31:0]            cpRdata_r,
  // Fetch and execute side of the core pipeline
  input  ibu_pkg::ibu_fetch_s    fetch,
  input  wire logic              pipeAdvance,
  input  wire logic              pipeFlush,
  input  ibu_pkg::ibu_exec_s     exec,
  // Exception side
  output logic                   prefetchAbort_r,
  output logic [31:0]            abortPc_r,
  output logic                   armed_r
);

  // ------------------------------------------------------------------
  // Break register fields
  // ------------------------------------------------------------------
  logic                          breakEn_r;
  logic [29:0]                   breakAddr_r;
  logic [31:0]                   instrBreakAddrCtrl;

  // Access handshake state
  ibu_pkg::ibu_cp_state_e        cpState_r;
  ibu_pkg::ibu_cp_state_e        cpState_nxt;
  ibu_pkg::ibu_cp_req_s          cpHeld_r;

  // Decode of incoming and held requests
  logic                          cpForUs;
  logic                          cpGrant;
  logic                          cpWriteDo;
  logic                          cpReadDo;

  // Match path
  logic                          fetchHit;
  ibu_pkg::ibu_entry_s           fetchEntry;
  ibu_pkg::ibu_entry_s           headEntry;
  logic                          execHit;

  // Read view of the register; reserved bit reads as zero
  always_comb begin
    instrBreakAddrCtrl                                   = ibu_pkg::READ_IDLE;
    instrBreakAddrCtrl[ibu_pkg::ADDR_MSB:ibu_pkg::ADDR_LSB] = breakAddr_r;
    instrBreakAddrCtrl[ibu_pkg::RSVD_BIT]                = 1'b0;
    instrBreakAddrCtrl[ibu_pkg::EN_BIT]                  = breakEn_r;
  end

  // ------------------------------------------------------------------
  // Coprocessor access decode
  // ------------------------------------------------------------------

  // Only coprocessor 15 register 14 belongs to this unit; others pass by
  assign cpForUs = cpReq.valid
                   && (cpReq.cpNum == ibu_pkg::CP_NUM_SYS)
                   && (cpReq.crn == ibu_pkg::CRN_BREAK);

  // Privilege is judged on the held copy so the answer is stable
  assign cpGrant   = (cpState_r == ibu_pkg::IBU_CP_RESP) && cpHeld_r.privileged;
  assign cpWriteDo = cpGrant && cpHeld_r.write;
  assign cpReadDo  = cpGrant && !cpHeld_r.write;

  // Next state of the access handshake
  always_comb begin
    cpState_nxt = cpState_r;
    case (cpState_r)
      ibu_pkg::IBU_CP_IDLE: begin
        if (cpForUs) begin
          cpState_nxt = ibu_pkg::IBU_CP_RESP;
        end
      end
      ibu_pkg::IBU_CP_RESP: begin
        cpState_nxt = ibu_pkg::IBU_CP_IDLE;
      end
      default: begin
        cpState_nxt = ibu_pkg::IBU_CP_IDLE;
      end
    endcase
  end

  // Handshake state register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cpState_r <= ibu_pkg::IBU_CP_IDLE;
    end else begin
      cpState_r <= cpState_nxt;
    end
  end

  // Request capture; requests during the answer cycle are not taken
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cpHeld_r <= '0;
    end else if ((cpState_r == ibu_pkg::IBU_CP_IDLE) && cpForUs) begin
      cpHeld_r <= cpReq;
    end
  end

  // Busy shows the cycle in which a new request would be ignored
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cpBusy_r <= 1'b0;
    end else begin
      cpBusy_r <= (cpState_nxt == ibu_pkg::IBU_CP_RESP);
    end
  end

  // Answer pulses: accepted when privileged, undefined otherwise
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cpAccept_r <= 1'b0;
      cpUndef_r  <= 1'b0;
    end else begin
      cpAccept_r <= cpGrant;
      cpUndef_r  <= (cpState_r == ibu_pkg::IBU_CP_RESP) && !cpHeld_r.privileged;
    end
  end

  // Read data is held only for the answer pulse, zero otherwise
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cpRdValid_r <= 1'b0;
      cpRdata_r   <= ibu_pkg::READ_IDLE;
    end else begin
      cpRdValid_r <= cpReadDo;
      cpRdata_r   <= cpReadDo ? instrBreakAddrCtrl : ibu_pkg::READ_IDLE;
    end
  end

  // ------------------------------------------------------------------
  // Break register
  // ------------------------------------------------------------------

  // Enable clears on reset so nothing fires before software arms it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      breakEn_r <= ibu_pkg::EN_RESET;
    end else if (cpWriteDo) begin
      breakEn_r <= cpHeld_r.wdata[ibu_pkg::EN_BIT];
    end
  end

  // Address field; the reserved bit is never stored
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      breakAddr_r <= ibu_pkg::ADDR_RESET;
    end else if (cpWriteDo) begin
      breakAddr_r <= cpHeld_r.wdata[ibu_pkg::ADDR_MSB:ibu_pkg::ADDR_LSB];
    end
  end

  // Armed status mirrors the enable bit
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      armed_r <= 1'b0;
    end else begin
      armed_r <= cpWriteDo ? cpHeld_r.wdata[ibu_pkg::EN_BIT] : breakEn_r;
    end
  end

  // ------------------------------------------------------------------
  // Fetch-side comparison
  // ------------------------------------------------------------------

  // Word compare only: the two low address bits never take part
  assign fetchHit = breakEn_r && fetch.valid
                    && (fetch.addr[ibu_pkg::ADDR_MSB:ibu_pkg::ADDR_LSB] == breakAddr_r);

  always_comb begin
    fetchEntry       = '0;
    fetchEntry.valid = fetch.valid;
    fetchEntry.hit   = fetchHit;
    fetchEntry.addr  = fetch.addr[ibu_pkg::ADDR_MSB:ibu_pkg::ADDR_LSB];
  end

  // Tags follow the instruction so a hit on a fetched but discarded
  // instruction never aborts; a register write drops older tags
  ibu_match_pipe u_match_pipe (
    .sys_clk     (sys_clk),
    .nrst        (nrst),
    .pipeAdvance (pipeAdvance),
    .pipeFlush   (pipeFlush),
    .dropHits    (cpWriteDo),
    .fetchEntry  (fetchEntry),
    .headEntry   (headEntry)
  );

  // ------------------------------------------------------------------
  // Execute-side qualification
  // ------------------------------------------------------------------

  // The tagged fetch address must equal the PC now executing
  assign execHit = exec.valid && pipeAdvance && !pipeFlush
                   && headEntry.valid && headEntry.hit && breakEn_r
                   && (exec.pc[ibu_pkg::ADDR_MSB:ibu_pkg::ADDR_LSB] == headEntry.addr);

  // One-cycle abort request in the cycle after the selected instruction executes; the
  // handler tells it from other aborts by the saved return pointer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prefetchAbort_r <= 1'b0;
    end else begin
      prefetchAbort_r <= execHit;
    end
  end

  // PC of the aborting instruction, kept until the next abort
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      abortPc_r <= ibu_pkg::READ_IDLE;
    end else if (execHit) begin
      abortPc_r <= exec.pc;
    end
  end

endmodule

// ===== src/ibu_match_pipe.sv
// Pipe of fetch-hit tags that follows instructions from fetch to execution
`timescale 1ns/1ps

module ibu_match_pipe (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              pipeAdvance,
  input  wire logic              pipeFlush,
  input  wire logic              dropHits,
  input  ibu_pkg::ibu_entry_s    fetchEntry,
  output ibu_pkg::ibu_entry_s    headEntry
);

  ibu_pkg::ibu_entry_s stage_r [ibu_pkg::PIPE_DEPTH];

  // Each stage shifts on advance; a flush kills every entry so a discarded
  // path never raises an abort
  genvar gi;
  generate
    for (gi = 0; gi < ibu_pkg::PIPE_DEPTH; gi++) begin : gStage
      ibu_pkg::ibu_entry_s feed;
      if (gi == 0) begin : gFirst
        assign feed = fetchEntry;
      end else begin : gRest
        assign feed = stage_r[gi-1];
      end
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          stage_r[gi] <= '0;
        end else if (pipeFlush) begin
          stage_r[gi] <= '0;
        end else begin
          if (pipeAdvance) begin
            stage_r[gi] <= feed;
          end
          // A rewritten breakpoint must not fire on stale hits
          if (dropHits) begin
            stage_r[gi].hit <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign headEntry = stage_r[ibu_pkg::PIPE_DEPTH-1];

endmodule

// ===== tb/ibu_breakpoint_assertions.sv
// Port-level concurrent checks for the instruction breakpoint unit
`timescale 1ns/1ps
module ibu_breakpoint_assertions (
  input  wire logic            sys_clk,
  input  wire logic            nrst,
  input  ibu_pkg::ibu_cp_req_s cpReq,
  input  wire logic            cpBusy_r,
  input  wire logic            cpAccept_r,
  input  wire logic            cpUndef_r,
  input  wire logic            cpRdValid_r,
  input  wire logic [31:0]     cpRdata_r,
  input  ibu_pkg::ibu_fetch_s  fetch,
  input  wire logic            pipeAdvance,
  input  wire logic            pipeFlush,
  input  ibu_pkg::ibu_exec_s   exec,
  input  wire logic            prefetchAbort_r,
  input  wire logic [31:0]     abortPc_r,
  input  wire logic            armed_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // A request is taken only when idle and aimed at the breakpoint register
  sequence s_take;
    cpReq.valid && !cpBusy_r && cpReq.cpNum == ibu_pkg::CP_NUM_SYS
      && cpReq.crn == ibu_pkg::CRN_BREAK;
  endsequence
  sequence s_answer;
    cpBusy_r ##1 (cpAccept_r || cpUndef_r);
  endsequence

  AST_TAKE: assert property (
    s_take |=> s_answer)
    else $error("breakpoint register access not answered");
  AST_UNPRIV: assert property (
    s_take ##0 !cpReq.privileged |-> ##2 cpUndef_r && !cpAccept_r)
    else $error("user mode access not refused");
  AST_PRIV: assert property (
    s_take ##0 cpReq.privileged |-> ##2 cpAccept_r && !cpUndef_r)
    else $error("privileged access not accepted");
  AST_ARM: assert property (
    s_take ##0 (cpReq.privileged && cpReq.write) |-> ##3 armed_r == $past(cpReq.wdata[0], 3))
    else $error("enable does not follow written bit 0");
  AST_RDBITS: assert property (
    cpRdValid_r |-> cpRdata_r[1:0] == {1'b0, armed_r})
    else $error("read of low bits wrong");
  AST_RDPRIV: assert property (
    cpRdValid_r |-> cpAccept_r && !cpUndef_r)
    else $error("read data without accepted access");
  AST_ABORT: assert property (
    prefetchAbort_r |-> $past(exec.valid) && $past(pipeAdvance) && abortPc_r == $past(exec.pc))
    else $error("abort without executed instruction");
  AST_ARMED: assert property (
    prefetchAbort_r |-> $past(armed_r))
    else $error("abort while disarmed");
endmodule

// ===== tb/ibu_breakpoint_tb_top.sv
// Self-checking bench for the instruction breakpoint unit
`timescale 1ns/1ps
module ibu_breakpoint_tb_top;
  logic                 sys_clk, nrst, run, acc, und, rv;
  logic                 busy, accR, undR, rvR, adv, flush, pa, armed;
  logic [31:0]          base, rd, rdR, apc, spr;
  int                   mismatches = 0, n_checks = 0, cyc = 0, nAbort = 0;
  ibu_pkg::ibu_cp_req_s cpReq;
  ibu_pkg::ibu_fetch_s  fetch;
  ibu_pkg::ibu_exec_s   exec;

  ibu_breakpoint i_dut (.sys_clk(sys_clk), .nrst(nrst), .cpReq(cpReq), .cpBusy_r(busy),
    .cpAccept_r(accR), .cpUndef_r(undR), .cpRdValid_r(rvR), .cpRdata_r(rdR),
    .fetch(fetch), .pipeAdvance(adv), .pipeFlush(flush), .exec(exec),
    .prefetchAbort_r(pa), .abortPc_r(apc), .armed_r(armed));
  ibu_core_model i_core (.sys_clk(sys_clk), .nrst(nrst), .run(run), .base(base),
    .prefetchAbort_r(pa), .abortPc_r(apc), .fetch(fetch), .pipeAdvance(adv),
    .pipeFlush(flush), .exec(exec), .savedReturnPointer(spr));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Run is under a hundred cycles; the ceiling leaves wide margin
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (pa === 1'b1) nAbort++;
    if (cyc == 3000) begin
      mismatches++;
      test_done();
    end
  end

  task test_done();
    $display("mismatches %0d checks %0d", mismatches, n_checks);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask

  // Valid drops once taken; a held valid would be taken again after the answer
  task cp(input logic wr, input logic pv, input logic [3:0] num, input logic [31:0] d);
    @(posedge sys_clk);
    cpReq <= '{1'b1, wr, num, ibu_pkg::CRN_BREAK, pv, d};
    @(posedge sys_clk);
    cpReq.valid <= 1'b0;
    @(posedge sys_clk);
    #1;
    acc = accR;
    und = undR;
    rv = rvR;
    rd = rdR;
    @(posedge sys_clk);
    #1;
  endtask

  // A short run stops the stream before late fetches reach execution
  task stream(input logic [31:0] b, input int n);
    @(posedge sys_clk);
    base <= b;
    @(posedge sys_clk);
    run <= 1'b1;
    repeat (n) @(posedge sys_clk);
    run <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  initial begin
    cpReq = '0;
    nrst = 1'b0;
    run = 1'b0;
    base = '0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    chk("armed", 32'h0, {31'h0, armed});
    cp(1'b0, 1'b1, ibu_pkg::CP_NUM_SYS, 32'h0);
    chk("read", 32'h0, rd);
    chk("rdvalid", 32'h1, {31'h0, rv});
    cp(1'b1, 1'b1, ibu_pkg::CP_NUM_SYS, 32'h0000_1043);
    chk("accept", 32'h1, {31'h0, acc});
    chk("armed", 32'h1, {31'h0, armed});
    cp(1'b0, 1'b1, ibu_pkg::CP_NUM_SYS, 32'h0);
    chk("read", 32'h0000_1041, rd);
    cp(1'b1, 1'b0, ibu_pkg::CP_NUM_SYS, 32'h0);
    chk("undef", 32'h1, {31'h0, und});
    cp(1'b0, 1'b0, ibu_pkg::CP_NUM_SYS, 32'h0);
    chk("user rdata", 32'h0, rd);
    chk("user undef", 32'h1, {31'h0, und});
    cp(1'b1, 1'b1, 4'h7, 32'h0);
    chk("other cp", 32'h0, {30'h0, acc, und});
    stream(32'h0000_1038, 8);
    chk("aborts", 32'h1, nAbort);
    chk("saved pc", 32'h0000_1040, spr);
    cp(1'b1, 1'b1, ibu_pkg::CP_NUM_SYS, 32'h0000_1040);
    stream(32'h0000_1038, 8);
    chk("disarmed", 32'h1, nAbort);
    cp(1'b1, 1'b1, ibu_pkg::CP_NUM_SYS, 32'h0000_1041);
    stream(32'h0000_1038, 4);
    chk("cut stream", 32'h1, nAbort);
    chk("armed", 32'h1, {31'h0, armed});
    // Reset after the last stream must disarm a programmed breakpoint
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    chk("reset armed", 32'h0, {31'h0, armed});
    cp(1'b0, 1'b1, ibu_pkg::CP_NUM_SYS, 32'h0);
    chk("reset read", 32'h0, rd);
    test_done();
  end
endmodule

bind ibu_breakpoint ibu_breakpoint_assertions i_chk (.sys_clk(sys_clk), .nrst(nrst),
  .cpReq(cpReq), .cpBusy_r(cpBusy_r), .cpAccept_r(cpAccept_r), .cpUndef_r(cpUndef_r),
  .cpRdValid_r(cpRdValid_r), .cpRdata_r(cpRdata_r), .fetch(fetch),
  .pipeAdvance(pipeAdvance), .pipeFlush(pipeFlush), .exec(exec),
  .prefetchAbort_r(prefetchAbort_r), .abortPc_r(abortPc_r), .armed_r(armed_r));

// ===== tb/ibu_core_model.sv
// Core fetch pipeline and abort handler facing the breakpoint unit
`timescale 1ns/1ps
module ibu_core_model (
  input  wire logic           sys_clk,
  input  wire logic           nrst,
  input  wire logic           run,
  input  wire logic [31:0]    base,
  input  wire logic           prefetchAbort_r,
  input  wire logic [31:0]    abortPc_r,
  output ibu_pkg::ibu_fetch_s fetch,
  output logic                pipeAdvance,
  output logic                pipeFlush,
  output ibu_pkg::ibu_exec_s  exec,
  output logic [31:0]         savedReturnPointer
);
  logic [31:0]         pc_r;
  ibu_pkg::ibu_fetch_s st0_r;
  ibu_pkg::ibu_fetch_s st1_r;

  // Straight-line fetch; a stopped stream empties the stages and reloads base
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pc_r <= '0;
      st0_r <= '0;
      st1_r <= '0;
    end else if (!run) begin
      pc_r <= base;
      st0_r <= '0;
      st1_r <= '0;
    end else begin
      pc_r <= pc_r + 32'h4;
      st0_r <= fetch;
      st1_r <= st0_r;
    end
  end

  // Idle address lines show the inverse, so a stale copy cannot pass for a fetch
  assign fetch = '{run, run ? pc_r : ~pc_r};
  assign pipeAdvance = run;
  assign pipeFlush = !run; // A stopped stream discards whatever is still in flight
  assign exec = '{run && st1_r.valid, st1_r.addr};

  // Handler keeps the return pointer to tell a breakpoint from other aborts
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      savedReturnPointer <= '0;
    end else if (prefetchAbort_r) begin
      savedReturnPointer <= abortPc_r;
    end
  end
endmodule
